//--- common/mmsm_pkg.sv
// Constants and types shared by the mixed-sign MAC slice
package mmsm_pkg;
	localparam int OPND_W = 16;
	localparam int PROD_W = 32;
	localparam int ACC_W = 40;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int RADDR_W = 8;
	localparam int NFLAG = 7;
	localparam int NIRQ = 3;
	// Instruction word bytes
	localparam logic [7:0] PREFIX_BYTE = 8'h93;
	localparam logic [7:0] OPC_US_RSUB = 8'hB8;
	localparam logic [7:0] OPC_SU_ADDRND = 8'h59;
	localparam int PREFIX_LSB = 24;
	localparam int XM_LSB = 16;
	localparam int OPC_LSB = 8;
	localparam int GPR_LSB = 0;
	// Arithmetic constants
	localparam logic [ACC_W-1:0] ROUND_CONST = 40'h00_0000_8000;
	localparam logic [ACC_W-1:0] SAT_POS = 40'h00_7FFF_FFFF;
	localparam logic [ACC_W-1:0] SAT_NEG = 40'hFF_8000_0000;
	localparam logic [ACC_W-1:0] LOW_CLEAR_MASK = 40'hFF_FFFF_0000;
	localparam logic [ADDR_W-1:0] MOVE_STEP = 16'h0002;
	// Flag bit positions
	localparam int FLAG_N = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_C = 2;
	localparam int FLAG_SV = 3;
	localparam int FLAG_E = 4;
	localparam int FLAG_SL = 5;
	localparam int FLAG_V = 6;
	// Interrupt status bit positions
	localparam int IRQ_OVF = 0;
	localparam int IRQ_SAT = 1;
	localparam int IRQ_ILL = 2;
	// Register offsets
	localparam logic [RADDR_W-1:0] REG_ACC_LO = 8'h00;
	localparam logic [RADDR_W-1:0] REG_ACC_EXT = 8'h04;
	localparam logic [RADDR_W-1:0] REG_FLAGS = 8'h08;
	localparam logic [RADDR_W-1:0] REG_CTRL = 8'h0C;
	localparam logic [RADDR_W-1:0] REG_IRQ_STAT = 8'h10;
	localparam logic [RADDR_W-1:0] REG_IRQ_MASK = 8'h14;
	// Reset values
	localparam logic [ACC_W-1:0] ACC_RST = 40'h00_0000_0000;
	localparam logic [NFLAG-1:0] FLAGS_RST = 7'h00;
	localparam logic CTRL_SAT_RST = 1'b0;
	localparam logic [NIRQ-1:0] IRQ_MASK_RST = 3'h0;
	typedef enum logic [1:0] {
		OP_NONE,
		OP_US_RSUB,
		OP_SU_ADDRND
	} mmsm_op_e;
endpackage : mmsm_pkg

//--- logic/mmsm_mult.sv
// Mixed-sign 16 by 16 multiplier giving a signed 32-bit product
module mmsm_mult
	import mmsm_pkg::*;
(
	input wire logic [mmsm_pkg::OPND_W-1:0] op_a,
	input wire logic a_signed,
	input wire logic [mmsm_pkg::OPND_W-1:0] op_b,
	input wire logic b_signed,
	output logic [mmsm_pkg::PROD_W-1:0] product
);
	logic signed [OPND_W:0] a_ext;
	logic signed [OPND_W:0] b_ext;
	logic signed [2*OPND_W+1:0] full;

	// One extra bit per operand lets one signed multiplier serve every mix
	assign a_ext = $signed({a_signed & op_a[OPND_W-1], op_a});
	assign b_ext = $signed({b_signed & op_b[OPND_W-1], op_b});
	assign full = a_ext * b_ext;
	// Unsigned times signed always fits 32 signed bits
	assign product = full[PROD_W-1:0];
endmodule : mmsm_mult

//--- logic/mmsm_core.sv
// Mixed-sign multiply-accumulate slice with parallel data move
module mmsm_core (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic instr_valid,
	input wire logic [31:0] instr_word,
	input wire logic [mmsm_pkg::OPND_W-1:0] op1,
	input wire logic [mmsm_pkg::OPND_W-1:0] op2,
	input wire logic [mmsm_pkg::ADDR_W-1:0] index_pointer,
	input wire logic [mmsm_pkg::OPND_W-1:0] mem_rd_data,
	input wire logic [mmsm_pkg::RADDR_W-1:0] reg_addr,
	input wire logic [mmsm_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [mmsm_pkg::DATA_W-1:0] reg_rdata,
	output logic [mmsm_pkg::ACC_W-1:0] product_sum_register,
	output logic [mmsm_pkg::NFLAG-1:0] flags_out,
	output logic op_done,
	output logic mem_rd_en,
	output logic [mmsm_pkg::ADDR_W-1:0] mem_rd_addr,
	output logic mem_wr_en,
	output logic [mmsm_pkg::ADDR_W-1:0] mem_wr_addr,
	output logic [mmsm_pkg::OPND_W-1:0] mem_wr_data,
	output logic irq
);
	import mmsm_pkg::*;

	function automatic mmsm_op_e decode_op(input logic [31:0] w);
		mmsm_op_e r;
		r = OP_NONE;
		if (w[PREFIX_LSB +: 8] == PREFIX_BYTE) begin
			if (w[OPC_LSB +: 8] == OPC_US_RSUB) begin
				r = OP_US_RSUB;
			end else if (w[OPC_LSB +: 8] == OPC_SU_ADDRND) begin
				r = OP_SU_ADDRND;
			end
		end
		return r;
	endfunction : decode_op

	function automatic logic ext_in_use(input logic [ACC_W-1:0] v);
		return !(&v[ACC_W-1:PROD_W-1] || ~|v[ACC_W-1:PROD_W-1]);
	endfunction : ext_in_use

	mmsm_op_e op;
	logic go;
	logic illegal;
	logic is_sub;
	logic is_rnd;
	logic [PROD_W-1:0] product;
	logic [ACC_W-1:0] ext_prod;
	logic [ACC_W-1:0] acc_term;
	logic [ACC_W-1:0] rnd_term;
	logic [ACC_W:0] sum_u;
	logic [ACC_W:0] sum_s;
	logic carry_out;
	logic ovf;
	logic sat;
	logic [ACC_W-1:0] sat_val;
	logic [ACC_W-1:0] final_val;
	logic [ACC_W-1:0] acc_reg;
	logic [ACC_W-1:0] acc_next;
	logic [NFLAG-1:0] flags_reg;
	logic [NFLAG-1:0] flags_next;
	logic sat_en_reg;
	logic [NIRQ-1:0] irq_stat_reg;
	logic [NIRQ-1:0] irq_mask_reg;
	logic [NIRQ-1:0] irq_event;
	logic [DATA_W-1:0] rdata_next;
	logic move_pend_reg;
	logic [ADDR_W-1:0] move_dest_reg;
	logic wr_acc_lo;
	logic wr_acc_ext;
	logic wr_flags;
	logic wr_ctrl;
	logic wr_irq_stat;
	logic wr_irq_mask;

	assign op = decode_op(instr_word);
	assign go = instr_valid && (op != OP_NONE);
	assign illegal = instr_valid && (decode_op(instr_word) == OP_NONE);
	// Decoded prefix and opcode pick subtract and round; saturation follows the CTRL register bit
	assign is_sub = (op == OP_US_RSUB);
	assign is_rnd = (op == OP_SU_ADDRND);

	// First operand signed only for the add-and-round form
	mmsm_mult u_mult (
		.op_a(op1),
		.a_signed(is_rnd),
		.op_b(op2),
		.b_signed(is_sub),
		.product(product)
	);

	assign ext_prod = {{(ACC_W-PROD_W){product[PROD_W-1]}}, product};

	// One adder: reverse subtract is product plus inverted accumulator plus one
	always_comb begin
		acc_term = is_sub ? ~acc_reg : acc_reg;
		rnd_term = is_rnd ? ROUND_CONST : '0;
		sum_u = {1'b0, ext_prod} + {1'b0, acc_term} + {1'b0, rnd_term} + {{ACC_W{1'b0}}, is_sub};
		sum_s = {ext_prod[ACC_W-1], ext_prod} + {acc_term[ACC_W-1], acc_term}
			+ {1'b0, rnd_term} + {{ACC_W{1'b0}}, is_sub};
		// Borrow is the inverse of the adder carry when subtracting
		carry_out = is_sub ? ~sum_u[ACC_W] : sum_u[ACC_W];
		ovf = sum_s[ACC_W] ^ sum_s[ACC_W-1];
	end

	// Saturate to the 32-bit signed range, sign taken before the wrap
	always_comb begin
		sat = 1'b0;
		sat_val = sum_s[ACC_W-1:0];
		if (sat_en_reg) begin
			if (ovf) begin
				sat = 1'b1;
				sat_val = sum_s[ACC_W] ? SAT_NEG : SAT_POS;
			end else if (ext_in_use(sum_s[ACC_W-1:0])) begin
				sat = 1'b1;
				sat_val = sum_s[ACC_W-1] ? SAT_NEG : SAT_POS;
			end
		end
		// Low word cleared last so rounding always ends on a word boundary
		final_val = is_rnd ? (sat_val & LOW_CLEAR_MASK) : sat_val;
	end

	always_comb begin
		flags_next = flags_reg;
		if (go) begin
			flags_next[FLAG_V] = ovf;
			flags_next[FLAG_C] = carry_out;
			flags_next[FLAG_Z] = (final_val == '0);
			flags_next[FLAG_N] = final_val[ACC_W-1];
			flags_next[FLAG_E] = ext_in_use(final_val);
			if (ovf) begin
				flags_next[FLAG_SV] = 1'b1;
			end
			if (sat) begin
				flags_next[FLAG_SL] = 1'b1;
			end
		end
		// Software clears sticky flags by writing one; a new event still wins
		if (wr_flags) begin
			if (reg_wdata[FLAG_SV] && !(go && ovf)) begin
				flags_next[FLAG_SV] = 1'b0;
			end
			if (reg_wdata[FLAG_SL] && !(go && sat)) begin
				flags_next[FLAG_SL] = 1'b0;
			end
		end
	end

	assign wr_acc_lo = reg_wr && (reg_addr == REG_ACC_LO);
	assign wr_acc_ext = reg_wr && (reg_addr == REG_ACC_EXT);
	assign wr_flags = reg_wr && (reg_addr == REG_FLAGS);
	assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
	assign wr_irq_stat = reg_wr && (reg_addr == REG_IRQ_STAT);
	assign wr_irq_mask = reg_wr && (reg_addr == REG_IRQ_MASK);

	// Instruction result takes priority over a software load in the same cycle
	always_comb begin
		acc_next = acc_reg;
		if (go) begin
			acc_next = final_val;
		end else begin
			if (wr_acc_lo) begin
				acc_next[PROD_W-1:0] = reg_wdata;
			end
			if (wr_acc_ext) begin
				acc_next[ACC_W-1:PROD_W] = reg_wdata[ACC_W-PROD_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			acc_reg <= ACC_RST;
		end else begin
			acc_reg <= acc_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			flags_reg <= FLAGS_RST;
		end else begin
			flags_reg <= flags_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			op_done <= 1'b0;
		end else begin
			op_done <= go;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			sat_en_reg <= CTRL_SAT_RST;
		end else if (wr_ctrl) begin
			sat_en_reg <= reg_wdata[0];
		end
	end

	// Move: read at the pointer, write only once the memory has answered
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			mem_rd_en <= 1'b0;
			mem_rd_addr <= '0;
			move_pend_reg <= 1'b0;
			move_dest_reg <= '0;
		end else begin
			mem_rd_en <= go;
			move_pend_reg <= mem_rd_en;
			move_dest_reg <= mem_rd_addr - MOVE_STEP;
			if (go) begin
				mem_rd_addr <= index_pointer;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			mem_wr_en <= 1'b0;
			mem_wr_addr <= '0;
			mem_wr_data <= '0;
		end else begin
			mem_wr_en <= move_pend_reg;
			if (move_pend_reg) begin
				mem_wr_addr <= move_dest_reg;
				mem_wr_data <= mem_rd_data;
			end
		end
	end

	assign irq_event[IRQ_OVF] = go && ovf;
	assign irq_event[IRQ_SAT] = go && sat;
	assign irq_event[IRQ_ILL] = illegal;

	genvar gi;
	generate
		for (gi = 0; gi < NIRQ; gi++) begin : g_irq
			// Set beats write-one-to-clear so no event is lost
			always_ff @(posedge clk_sys) begin
				if (!nrst) begin
					irq_stat_reg[gi] <= 1'b0;
				end else if (irq_event[gi]) begin
					irq_stat_reg[gi] <= 1'b1;
				end else if (wr_irq_stat && reg_wdata[gi]) begin
					irq_stat_reg[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			irq_mask_reg <= IRQ_MASK_RST;
		end else if (wr_irq_mask) begin
			irq_mask_reg <= reg_wdata[NIRQ-1:0];
		end
	end

	// Irq is registered, so it trails the status bit by one cycle
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	always_comb begin
		rdata_next = '0;
		case (reg_addr)
			REG_ACC_LO: rdata_next = acc_reg[PROD_W-1:0];
			REG_ACC_EXT: rdata_next[ACC_W-PROD_W-1:0] = acc_reg[ACC_W-1:PROD_W];
			REG_FLAGS: rdata_next[NFLAG-1:0] = flags_reg;
			REG_CTRL: rdata_next[0] = sat_en_reg;
			REG_IRQ_STAT: rdata_next[NIRQ-1:0] = irq_stat_reg;
			REG_IRQ_MASK: rdata_next[NIRQ-1:0] = irq_mask_reg;
			default: rdata_next = '0;
		endcase
	end

	// Read data held only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= '0;
		end
	end

	assign product_sum_register = acc_reg;
	assign flags_out = flags_reg;
endmodule : mmsm_core

//--- test/mmsm_core_properties.sv
// Port-level assertions for the mixed-sign MAC slice
module mmsm_core_properties
	import mmsm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic instr_valid,
	input wire logic [31:0] instr_word,
	input wire logic [mmsm_pkg::ADDR_W-1:0] index_pointer,
	input wire logic [mmsm_pkg::ACC_W-1:0] product_sum_register,
	input wire logic [mmsm_pkg::NFLAG-1:0] flags_out,
	input wire logic op_done,
	input wire logic mem_rd_en,
	input wire logic [mmsm_pkg::ADDR_W-1:0] mem_rd_addr,
	input wire logic mem_wr_en
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic dec;
	logic [8:0] top;
	assign dec = instr_valid && instr_word[31:24] == PREFIX_BYTE
		&& (instr_word[15:8] == OPC_US_RSUB || instr_word[15:8] == OPC_SU_ADDRND);
	assign top = product_sum_register[39:31];
	sequence s_issue;
		dec;
	endsequence
	// Write trails the read by two cycles, after the memory answer
	sequence s_move;
		mem_rd_en && mem_rd_addr == $past(index_pointer) ##2 mem_wr_en;
	endsequence
	a_done_after_issue: assert property (s_issue |=> op_done) else $error("no op_done");
	a_bad_word_idle: assert property (instr_valid && !dec |=> !op_done && !mem_rd_en)
		else $error("undecoded word acted on");
	a_move_steps: assert property (s_issue |=> s_move) else $error("move missing");
	a_zero_flag: assert property (op_done |-> flags_out[FLAG_Z] == (product_sum_register == '0))
		else $error("zero flag wrong");
	a_neg_flag: assert property (op_done |-> flags_out[FLAG_N] == product_sum_register[ACC_W-1])
		else $error("negative flag wrong");
	a_ext_flag: assert property (op_done |-> flags_out[FLAG_E] == !(&top || !(|top)))
		else $error("extension flag wrong");
	a_low_word_clear: assert property (op_done && $past(instr_word[15:8]) == OPC_SU_ADDRND
		|-> product_sum_register[15:0] == '0) else $error("low word kept");
	a_sticky_follows: assert property (op_done && flags_out[FLAG_V] |-> flags_out[FLAG_SV])
		else $error("sticky overflow lost");
	a_sat_clamps: assert property ($rose(flags_out[FLAG_SL]) |-> product_sum_register == SAT_NEG
		|| product_sum_register == (SAT_POS & LOW_CLEAR_MASK) || product_sum_register == SAT_POS)
		else $error("saturation without clamp");
endmodule : mmsm_core_properties

bind mmsm_core mmsm_core_properties i_mmsm_core_properties (
	.clk_sys(clk_sys),
	.nrst(nrst),
	.instr_valid(instr_valid),
	.instr_word(instr_word),
	.index_pointer(index_pointer),
	.product_sum_register(product_sum_register),
	.flags_out(flags_out),
	.op_done(op_done),
	.mem_rd_en(mem_rd_en),
	.mem_rd_addr(mem_rd_addr),
	.mem_wr_en(mem_wr_en)
);

//--- test/mmsm_mem_model.sv
// Behavioural data memory answering the slice's move requests
module mmsm_mem_model
	import mmsm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic mem_rd_en,
	input wire logic [mmsm_pkg::ADDR_W-1:0] mem_rd_addr,
	input wire logic mem_wr_en,
	input wire logic [mmsm_pkg::ADDR_W-1:0] mem_wr_addr,
	input wire logic [mmsm_pkg::OPND_W-1:0] mem_wr_data,
	output logic [mmsm_pkg::OPND_W-1:0] mem_rd_data
);
	logic [OPND_W-1:0] mem [0:65535];
	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = 16'(i) ^ 16'h5A3C;
		mem_rd_data = 16'h0000;
	end
	// Stale data inverted so a late sample cannot match by luck
	always @(posedge clk_sys) begin
		mem_rd_data <= mem_rd_en ? mem[mem_rd_addr] : ~mem_rd_data;
		if (mem_wr_en) mem[mem_wr_addr] <= mem_wr_data;
	end
endmodule : mmsm_mem_model

//--- test/mmsm_bench.sv
// Self-checking bench for the mixed-sign MAC slice
module mmsm_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import mmsm_pkg::*;
`define chk(g, e, m) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %0t %s", $time, m); end end
	logic clk_sys = 0, nrst = 0, instr_valid = 0, reg_wr = 0, reg_rd = 0, sat_m = 0;
	logic op_done, mem_rd_en, mem_wr_en, irq;
	logic [31:0] instr_word = 0;
	logic [OPND_W-1:0] op1 = 0, op2 = 0, mem_rd_data, mem_wr_data;
	logic [ADDR_W-1:0] index_pointer = 0, mem_rd_addr, mem_wr_addr;
	logic [RADDR_W-1:0] reg_addr = 0;
	logic [DATA_W-1:0] reg_wdata = 0, reg_rdata;
	logic [ACC_W-1:0] product_sum_register, acc_m = 0;
	logic [NFLAG-1:0] flags_out, flg_m = 0;
	logic [2:0] ist_m = 0;
	logic [15:0] ptrs[$];
	int n_fail = 0, n_checks = 0, cyc = 0;
	mmsm_core i_mmsm_core (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.instr_valid(instr_valid),
		.instr_word(instr_word),
		.op1(op1),
		.op2(op2),
		.index_pointer(index_pointer),
		.mem_rd_data(mem_rd_data),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.product_sum_register(product_sum_register),
		.flags_out(flags_out),
		.op_done(op_done),
		.mem_rd_en(mem_rd_en),
		.mem_rd_addr(mem_rd_addr),
		.mem_wr_en(mem_wr_en),
		.mem_wr_addr(mem_wr_addr),
		.mem_wr_data(mem_wr_data),
		.irq(irq)
	);
	mmsm_mem_model i_mmsm_mem_model (
		.clk_sys(clk_sys),
		.mem_rd_en(mem_rd_en),
		.mem_rd_addr(mem_rd_addr),
		.mem_wr_en(mem_wr_en),
		.mem_wr_addr(mem_wr_addr),
		.mem_wr_data(mem_wr_data),
		.mem_rd_data(mem_rd_data)
	);
	initial forever #50 clk_sys = ~clk_sys;
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done
	// Ceiling well above the roughly 70 cycles the tests need
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			test_done();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 `chk(reg_rdata, e, "register read")
	endtask : rd
	task automatic set_acc(input logic [39:0] v);
		wr(REG_ACC_LO, v[31:0]);
		wr(REG_ACC_EXT, {24'h00_0000, v[39:32]});
		acc_m = v;
	endtask : set_acc
	task automatic exec(input logic [7:0] opc, input logic [15:0] a, input logic [15:0] b, input logic [15:0] ptr);
		longint p, s, au;
		logic v, sat, rs;
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr_word <= {PREFIX_BYTE, 8'h00, opc, 8'h00};
		op1 <= a;
		op2 <= b;
		index_pointer <= ptr;
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		rs = opc == OPC_US_RSUB;
		if (!rs && opc != OPC_SU_ADDRND) begin
			ist_m[2] = 1'b1;
			return;
		end
		ptrs.push_back(ptr);
		au = longint'(acc_m);
		p = rs ? longint'(a) * longint'($signed(b)) : longint'($signed(a)) * longint'(b);
		s = rs ? p - longint'($signed(acc_m)) : longint'($signed(acc_m)) + p + 32768;
		v = (s >>> 39) != 0 && (s >>> 39) != -1;
		sat = sat_m && (s >>> 31) != 0 && (s >>> 31) != -1;
		flg_m[FLAG_C] = rs ? (p & 64'h00FF_FFFF_FFFF) < au : ((au + (p & 64'h00FF_FFFF_FFFF) + 32768) >>> 40) != 0;
		acc_m = sat ? (s < 0 ? SAT_NEG : SAT_POS) : s[39:0];
		if (!rs) acc_m[15:0] = 16'h0000;
		flg_m[FLAG_V] = v;
		flg_m[FLAG_SV] |= v;
		flg_m[FLAG_SL] |= sat;
		flg_m[FLAG_Z] = acc_m == 40'h00_0000_0000;
		flg_m[FLAG_N] = acc_m[39];
		flg_m[FLAG_E] = !(&acc_m[39:31] || !(|acc_m[39:31]));
		ist_m |= {1'b0, sat, v};
	endtask : exec
	task automatic check_op(input string name);
		#1 `chk(product_sum_register, acc_m, "accumulator")
		`chk(flags_out, flg_m, "flags")
		$display("test %s done", name);
	endtask : check_op
	initial begin
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(REG_ACC_EXT, 32'h0000_0000);
		rd(REG_FLAGS, 32'h0000_0000);
		rd(REG_CTRL, 32'h0000_0000);
		rd(8'h20, 32'h0000_0000);
		exec(OPC_SU_ADDRND, 16'h7FFF, 16'hFFFF, 16'h0010);
		check_op("su add round");
		exec(OPC_US_RSUB, 16'hFFFF, 16'h8000, 16'h0014);
		check_op("us reverse sub");
		set_acc(40'h7F_FFFF_FFFF);
		exec(OPC_US_RSUB, 16'hFFFF, 16'h8000, 16'h0018);
		check_op("underflow");
		rd(REG_IRQ_STAT, {29'h0000_0000, ist_m});
		`chk(irq, 1'b0, "masked irq")
		wr(REG_IRQ_MASK, 32'h0000_0007);
		@(posedge clk_sys);
		#1 `chk(irq, 1'b1, "irq raise")
		wr(REG_IRQ_STAT, 32'h0000_0001);
		ist_m[0] = 1'b0;
		@(posedge clk_sys);
		#1 `chk(irq, 1'b0, "irq clear")
		exec(OPC_US_RSUB, 16'h0000, 16'h0000, 16'h001C);
		check_op("sticky kept");
		set_acc(40'hFF_FFFF_8000);
		exec(OPC_SU_ADDRND, 16'h0000, 16'h0000, 16'h0020);
		check_op("zero carry");
		set_acc(40'h7F_FFFF_0000);
		exec(OPC_SU_ADDRND, 16'h7FFF, 16'hFFFF, 16'h0024);
		check_op("overflow");
		wr(REG_FLAGS, 32'h0000_0028);
		flg_m[FLAG_SV] = 1'b0;
		rd(REG_FLAGS, {25'h000_0000, flg_m});
		wr(REG_CTRL, 32'h0000_0001);
		sat_m = 1'b1;
		set_acc(40'hFF_FF00_0000);
		exec(OPC_US_RSUB, 16'hFFFF, 16'h7FFF, 16'h0028);
		check_op("saturate");
		exec(8'h58, 16'h1234, 16'h5678, 16'h002C);
		check_op("bad word");
		rd(REG_IRQ_STAT, {29'h0000_0000, ist_m});
		repeat (3) @(posedge clk_sys);
		foreach (ptrs[i]) `chk(i_mmsm_mem_model.mem[ptrs[i] - MOVE_STEP], ptrs[i] ^ 16'h5A3C, "move")
		$display("test move done");
		test_done();
	end
endmodule : mmsm_bench
